// ### hw/sar_conv_defs.svh
// sar_conv_defs.svh: field positions, reset values and step counts
// for the converter start-of-conversion control.
// assumes: included by bare name from the design files only.
`ifndef SAR_CONV_DEFS_SVH
`define SAR_CONV_DEFS_SVH

// converter_control field positions
`define CC_ENABLE_BIT 7
`define CC_TRACK_BIT 6
`define CC_DONE_BIT 5
`define CC_BUSY_BIT 4
`define CC_WIN_BIT 3
`define CC_SRC_MSB 2
`define CC_SRC_LSB 0
`define CC_RESET 8'h00

// step counts, in converter-clock periods, and bus widths in bits
`define EXTRA_TRACK_TICKS 3
`define SAR_CONV_TICKS 11
`define DIVIDER_WIDTH 5
`define RESULT_WIDTH 10

`endif

// ### hw/sar_conv_pkg.sv
// sar_conv_pkg: types shared by the converter control modules.
// assumes: nothing beyond a SystemVerilog compiler.
package sar_conv_pkg;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXTRA_TRACK = 2'b01,
		ST_CONVERT = 2'b10
	} conv_state_t;

	// start_source_select codes
	typedef enum logic [2:0] {
		SRC_SOFTWARE = 3'b000,
		SRC_TIMER0 = 3'b001,
		SRC_TIMER2 = 3'b010,
		SRC_TIMER1 = 3'b011,
		SRC_STROBE = 3'b100,
		SRC_TIMER3 = 3'b101
	} start_src_t;

endpackage

// ### hw/sar_tick_if.sv
// sar_tick_if: divider setting and converter-clock tick between the
// control block and its clock divider.
// assumes: both ends on one system clock.
`timescale 1ns/10ps
`default_nettype none
`include "sar_conv_defs.svh"

interface sar_tick_if;
	logic [`DIVIDER_WIDTH-1:0] divide;
	logic tick;
	modport ctrl (output divide, input tick);
	modport divider (input divide, output tick);
endinterface

`default_nettype wire

// ### hw/sar_clock_divider.sv
// sar_clock_divider: makes the converter clock as a one-cycle enable.
// assumes: divide is stable while a conversion runs.
`timescale 1ns/10ps
`default_nettype none
`include "sar_conv_defs.svh"

module sar_clock_divider (
	input wire logic clk,
	input wire logic rst_n,
	sar_tick_if.divider tick_if
);

	logic [`DIVIDER_WIDTH-1:0] count;
	logic [`DIVIDER_WIDTH-1:0] next_count;
	logic next_tick;

	// one tick every divide+1 system clocks
	always_comb begin
		if (count >= tick_if.divide) begin
			next_count = '0;
			next_tick = 1'b1;
		end else begin
			next_count = count + 1'b1;
			next_tick = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= '0;
			tick_if.tick <= 1'b0;
		end else begin
			count <= next_count;
			tick_if.tick <= next_tick;
		end
	end

	// tick spacing for a steady divide of one
	tick_period_a: assert property (@(posedge clk) disable iff (!rst_n)
		(tick_if.tick && tick_if.divide == 5'h01 && $stable(tick_if.divide))
		|=> !tick_if.tick ##1 tick_if.tick)
		else $error("converter clock period not divide plus one");

endmodule

`default_nettype wire

// ### hw/sar_conversion_start_control.sv
// sar_conversion_start_control: start trigger selection, normal/delayed
// tracking, completion and window-compare flags for the SAR converter.
// assumes: timer overflows are one-cycle pulses on REF_CLK_IN; the strobe
// pin is asynchronous; the result word is valid at the end of conversion.
//
// Operation
// - normal mode tracks except while converting
// - normal mode converts at once on start
// - delayed mode tracks only when not converting
// - delayed mode adds three converter clocks tracking
// - software code: busy write one starts, zero ignored
// - codes 001/010/011/101 select timers 0/2/1/3
// - code 100: strobe rising edge starts
// - compare result to limits, set window flag
// - limit order picks inside or outside window
// - converter clock is system clock over divider+1
`timescale 1ns/10ps
`default_nettype none
`include "sar_conv_defs.svh"

module sar_conversion_start_control #(
	parameter int CONV_TICKS = `SAR_CONV_TICKS
) (
	input wire logic REF_CLK_IN,
	input wire logic RSTN_IN,
	input wire logic SFR_WR_IN,
	input wire logic [7:0] SFR_WDATA_IN,
	input wire logic [`DIVIDER_WIDTH-1:0] SAR_CLOCK_DIVIDER_IN,
	input wire logic [3:0] TIMER_OVF_IN,
	input wire logic EXTERNAL_CONVERT_STROBE_IN,
	input wire logic [`RESULT_WIDTH-1:0] SAR_RESULT_IN,
	input wire logic [`RESULT_WIDTH-1:0] LIMIT_GREATER_IN,
	input wire logic [`RESULT_WIDTH-1:0] LIMIT_LESS_IN,
	output logic [7:0] SFR_RDATA_OUT,
	output logic TRACK_OUT,
	output logic CONVERTING_OUT,
	output logic [`RESULT_WIDTH-1:0] RESULT_OUT
);

	// ****************************************
	// parameter check
	// ****************************************
	generate
		if (CONV_TICKS < 1 || CONV_TICKS > 15) begin : bad_ticks
			$error("CONV_TICKS must lie in 1..15");
		end
	endgenerate

	localparam logic [3:0] LAST_CONV = 4'(CONV_TICKS - 1);
	localparam logic [3:0] LAST_EXTRA = 4'(`EXTRA_TRACK_TICKS - 1);

	// ****************************************
	// converter clock
	// ****************************************
	sar_tick_if tick_if ();
	sar_clock_divider divider_u (
		.clk(REF_CLK_IN),
		.rst_n(RSTN_IN),
		.tick_if(tick_if.divider)
	);
	assign tick_if.divide = SAR_CLOCK_DIVIDER_IN;

	// ****************************************
	// strobe pin synchroniser
	// ****************************************
	logic strobe_meta, strobe_sync, strobe_last;
	// meta feeds only sync; edge looks at sync and last
	always_ff @(posedge REF_CLK_IN) begin
		if (!RSTN_IN) begin
			strobe_meta <= 1'b0;
			strobe_sync <= 1'b0;
			strobe_last <= 1'b0;
		end else begin
			strobe_meta <= EXTERNAL_CONVERT_STROBE_IN;
			strobe_sync <= strobe_meta;
			strobe_last <= strobe_sync;
		end
	end

	// ****************************************
	// control register and sequencer
	// ****************************************
	logic converter_enable, track_mode_select;
	logic conversion_done_flag, window_compare_flag;
	sar_conv_pkg::start_src_t start_source_select;
	sar_conv_pkg::conv_state_t state;
	logic [3:0] step;
	logic next_enable, next_mode, next_done, next_win;
	sar_conv_pkg::start_src_t next_src;
	sar_conv_pkg::conv_state_t next_state;
	logic [3:0] next_step;
	logic [`RESULT_WIDTH-1:0] next_result;
	logic start_evt, conv_end, in_window, win_hit, strobe_rise;

	assign strobe_rise = strobe_sync && !strobe_last;

	// start event from the selected source; spare codes start nothing
	always_comb begin
		case (start_source_select)
			sar_conv_pkg::SRC_SOFTWARE:
				start_evt = SFR_WR_IN && SFR_WDATA_IN[`CC_BUSY_BIT];
			sar_conv_pkg::SRC_TIMER0: start_evt = TIMER_OVF_IN[0];
			sar_conv_pkg::SRC_TIMER2: start_evt = TIMER_OVF_IN[2];
			sar_conv_pkg::SRC_TIMER1: start_evt = TIMER_OVF_IN[1];
			sar_conv_pkg::SRC_STROBE: start_evt = strobe_rise;
			sar_conv_pkg::SRC_TIMER3: start_evt = TIMER_OVF_IN[3];
			default: start_evt = 1'b0;
		endcase
	end

	// inside when less-limit above greater-limit, else outside
	always_comb begin
		if (LIMIT_LESS_IN > LIMIT_GREATER_IN) begin
			in_window = SAR_RESULT_IN > LIMIT_GREATER_IN &&
				SAR_RESULT_IN < LIMIT_LESS_IN;
		end else begin
			in_window = SAR_RESULT_IN < LIMIT_LESS_IN ||
				SAR_RESULT_IN > LIMIT_GREATER_IN;
		end
	end

	assign conv_end = state == sar_conv_pkg::ST_CONVERT && tick_if.tick &&
		step == LAST_CONV;
	assign win_hit = conv_end && in_window;

	// next state; a start while busy is ignored
	always_comb begin
		next_state = state;
		next_step = step;
		case (state)
			sar_conv_pkg::ST_IDLE: begin
				next_step = 4'h0;
				if (converter_enable && start_evt) begin
					if (track_mode_select) begin
						next_state = sar_conv_pkg::ST_EXTRA_TRACK;
					end else begin
						next_state = sar_conv_pkg::ST_CONVERT;
					end
				end
			end
			sar_conv_pkg::ST_EXTRA_TRACK: begin
				if (tick_if.tick) begin
					if (step == LAST_EXTRA) begin
						next_state = sar_conv_pkg::ST_CONVERT;
						next_step = 4'h0;
					end else begin
						next_step = step + 4'h1;
					end
				end
			end
			sar_conv_pkg::ST_CONVERT: begin
				if (tick_if.tick) begin
					if (conv_end) begin
						next_state = sar_conv_pkg::ST_IDLE;
						next_step = 4'h0;
					end else begin
						next_step = step + 4'h1;
					end
				end
			end
			default: begin
				next_state = sar_conv_pkg::ST_IDLE;
				next_step = 4'h0;
			end
		endcase
		// disabling powers down and abandons any conversion
		if (!converter_enable) begin
			next_state = sar_conv_pkg::ST_IDLE;
			next_step = 4'h0;
		end
	end

	// register writes; hardware set wins over a software clear
	always_comb begin
		next_enable = converter_enable;
		next_mode = track_mode_select;
		next_src = start_source_select;
		next_done = conversion_done_flag;
		next_win = window_compare_flag;
		next_result = RESULT_OUT;
		if (SFR_WR_IN) begin
			next_enable = SFR_WDATA_IN[`CC_ENABLE_BIT];
			next_mode = SFR_WDATA_IN[`CC_TRACK_BIT];
			next_src = sar_conv_pkg::start_src_t'(
				SFR_WDATA_IN[`CC_SRC_MSB:`CC_SRC_LSB]);
			next_done = SFR_WDATA_IN[`CC_DONE_BIT];
			next_win = SFR_WDATA_IN[`CC_WIN_BIT];
		end
		if (conv_end) begin
			next_done = 1'b1;
			next_result = SAR_RESULT_IN;
		end
		if (win_hit) begin
			next_win = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!RSTN_IN) begin
			converter_enable <= 1'b0;
			track_mode_select <= 1'b0;
			start_source_select <= sar_conv_pkg::SRC_SOFTWARE;
			conversion_done_flag <= 1'b0;
			window_compare_flag <= 1'b0;
			state <= sar_conv_pkg::ST_IDLE;
			step <= 4'h0;
			RESULT_OUT <= '0;
		end else begin
			converter_enable <= next_enable;
			track_mode_select <= next_mode;
			start_source_select <= next_src;
			conversion_done_flag <= next_done;
			window_compare_flag <= next_win;
			state <= next_state;
			step <= next_step;
			RESULT_OUT <= next_result;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// track while enabled and not converting, in either mode
	always_ff @(posedge REF_CLK_IN) begin
		if (!RSTN_IN) begin
			TRACK_OUT <= 1'b0;
			CONVERTING_OUT <= 1'b0;
			SFR_RDATA_OUT <= `CC_RESET;
		end else begin
			TRACK_OUT <= next_enable &&
				next_state != sar_conv_pkg::ST_CONVERT;
			CONVERTING_OUT <= next_state == sar_conv_pkg::ST_CONVERT;
			SFR_RDATA_OUT <= {next_enable, next_mode, next_done,
				next_state != sar_conv_pkg::ST_IDLE,
				next_win, 3'(next_src)};
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RSTN_IN);

	normal_start_a: assert property (
		state == sar_conv_pkg::ST_IDLE && converter_enable &&
		!track_mode_select && start_evt |=> CONVERTING_OUT)
		else $error("normal start did not convert at once");
	delayed_start_a: assert property (
		state == sar_conv_pkg::ST_IDLE && converter_enable &&
		track_mode_select && start_evt |=> TRACK_OUT && !CONVERTING_OUT)
		else $error("delayed start skipped extra tracking");
	extra_length_a: assert property (
		state == sar_conv_pkg::ST_EXTRA_TRACK && tick_if.tick &&
		step == 4'h2 && converter_enable |=> CONVERTING_OUT)
		else $error("extra tracking not three converter clocks");
	busy_zero_a: assert property (
		state == sar_conv_pkg::ST_IDLE &&
		start_source_select == sar_conv_pkg::SRC_SOFTWARE &&
		SFR_WR_IN && !SFR_WDATA_IN[`CC_BUSY_BIT]
		|=> !SFR_RDATA_OUT[`CC_BUSY_BIT])
		else $error("busy write of zero started a conversion");
	timer3_sel_a: assert property (
		state == sar_conv_pkg::ST_IDLE && converter_enable &&
		start_source_select == sar_conv_pkg::SRC_TIMER3 &&
		TIMER_OVF_IN[3] |=> SFR_RDATA_OUT[`CC_BUSY_BIT])
		else $error("timer 3 overflow did not start");
	strobe_edge_a: assert property (
		state == sar_conv_pkg::ST_IDLE && converter_enable &&
		start_source_select == sar_conv_pkg::SRC_STROBE &&
		!strobe_last && strobe_sync |=> SFR_RDATA_OUT[`CC_BUSY_BIT])
		else $error("strobe rising edge did not start");
	done_sticky_a: assert property (
		conv_end |=> SFR_RDATA_OUT[`CC_DONE_BIT] &&
		!SFR_RDATA_OUT[`CC_BUSY_BIT])
		else $error("done flag not set at conversion end");
	track_out_a: assert property (
		TRACK_OUT |-> converter_enable &&
		state != sar_conv_pkg::ST_CONVERT)
		else $error("tracking during a conversion");
	window_flag_a: assert property (
		conv_end && in_window |=> SFR_RDATA_OUT[`CC_WIN_BIT])
		else $error("window flag missed a match");
	window_order_a: assert property (
		LIMIT_LESS_IN > LIMIT_GREATER_IN && SAR_RESULT_IN <=
		LIMIT_GREATER_IN |-> !in_window)
		else $error("inside window took a low result");

endmodule

`default_nettype wire

// ### testbench/test_sar_conversion_start_control.sv
// test_sar_conversion_start_control: self-checking bench for the converter
// start control; assumes the hw/ files are compiled first.
`timescale 1ns/10ps
`default_nettype none

module test_sar_conversion_start_control;
	// ********************************
	// signals and design under test
	// ********************************
	logic clk, rst_n, wr, strobe;
	logic [7:0] wdata, rdata;
	logic [4:0] div;
	logic [3:0] ovf;
	logic [9:0] res, lim_gt, lim_lt, res_out;
	logic track, conv;
	int fail_count, checked, cycles, len, n;
	logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
	int timer_of [4] = '{0, 2, 1, 3};

	// short conversion keeps the run brief
	sar_conversion_start_control #(.CONV_TICKS(4)) dut (
		.REF_CLK_IN(clk),
		.RSTN_IN(rst_n),
		.SFR_WR_IN(wr),
		.SFR_WDATA_IN(wdata),
		.SAR_CLOCK_DIVIDER_IN(div),
		.TIMER_OVF_IN(ovf),
		.EXTERNAL_CONVERT_STROBE_IN(strobe),
		.SAR_RESULT_IN(res),
		.LIMIT_GREATER_IN(lim_gt),
		.LIMIT_LESS_IN(lim_lt),
		.SFR_RDATA_OUT(rdata),
		.TRACK_OUT(track),
		.CONVERTING_OUT(conv),
		.RESULT_OUT(res_out)
	);

	// ********************************
	// helpers
	// ********************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// a hang is cut short and counted as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic summarize;
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle write pulse, launched off the falling edge
	task automatic wr_reg(input logic [7:0] d);
		@(negedge clk);
		wr = 1'b1;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask

	// waits out a conversion; len counts cycles with converting high
	task automatic finish_conv;
		n = 0;
		len = 0;
		while (conv !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		while (conv === 1'b1 && len < 200) begin
			@(negedge clk);
			len++;
		end
		@(negedge clk);
	endtask

	// ********************************
	// scenarios
	// ********************************
	task automatic t_software;
		check(rdata, 8'h00);
		check(track, 1'b0);
		wr_reg(8'h80);
		@(negedge clk);
		check(track, 1'b1);
		wr_reg(8'h80);
		check(conv, 1'b0);
		// looked at right after the write so finish_conv sees every cycle
		wr_reg(8'h90);
		check({conv, track}, 2'b10);
		check(rdata[4], 1'b1);
		finish_conv();
		check(len >= 4 && len <= 5, 1'b1);
		check(track, 1'b1);
		check(rdata, 8'hA0);
		check(res_out, res);
		wr_reg(8'h80);
		@(negedge clk);
		check(rdata, 8'h80);
	endtask

	task automatic t_delayed;
		wr_reg(8'hC0);
		wr_reg(8'hD0);
		n = 0;
		while (conv !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
			if (n == 2)
				check({rdata[4], track}, 2'b11);
		end
		check(n >= 3 && n <= 5, 1'b1);
		check(track, 1'b0);
		finish_conv();
		check(track, 1'b1);
		wr_reg(8'h80);
	endtask

	// wrong timer first must start nothing, then the selected one
	task automatic t_timers;
		for (int i = 0; i < 4; i++) begin
			wr_reg({5'h10, codes[i]});
			ovf = 4'h1 << ((timer_of[i] + 1) % 4);
			@(negedge clk);
			ovf = 4'h0;
			@(negedge clk);
			check(conv, 1'b0);
			ovf = 4'h1 << timer_of[i];
			@(negedge clk);
			ovf = 4'h0;
			@(negedge clk);
			check(conv, 1'b1);
			finish_conv();
			wr_reg(8'h80);
		end
		// spare code: no timer and no busy write may start
		wr_reg(8'h86);
		ovf = 4'hF;
		@(negedge clk);
		ovf = 4'h0;
		wr_reg(8'h96);
		@(negedge clk);
		check(conv, 1'b0);
		check(rdata[4], 1'b0);
		wr_reg(8'h80);
	endtask

	// a strobe held high must not start a second conversion
	task automatic t_strobe;
		wr_reg(8'h84);
		strobe = 1'b1;
		finish_conv();
		check(n >= 2 && n <= 6, 1'b1);
		repeat (4) @(negedge clk);
		check(conv, 1'b0);
		strobe = 1'b0;
		wr_reg(8'h80);
	endtask

	task automatic win_case(input logic [9:0] lt, gt, r, input logic exp);
		lim_lt = lt;
		lim_gt = gt;
		res = r;
		wr_reg(8'h80);
		wr_reg(8'h90);
		finish_conv();
		check(rdata[3], exp);
	endtask

	task automatic t_divider;
		div = 5'h02;
		wr_reg(8'h90);
		finish_conv();
		check(len >= 10 && len <= 13, 1'b1);
		// divide of one also exercises the tick spacing check
		div = 5'h01;
		wr_reg(8'h90);
		finish_conv();
		check(len >= 7 && len <= 8, 1'b1);
		div = 5'h00;
		wr_reg(8'h80);
	endtask

	// ********************************
	// main sequence
	// ********************************
	initial begin
		{rst_n, wr, strobe, wdata, div, ovf} = '0;
		res = 10'h155;
		lim_lt = 10'h000;
		lim_gt = 10'h3FF;
		fail_count = 0;
		checked = 0;
		cycles = 0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		t_software();
		t_delayed();
		t_timers();
		t_strobe();
		t_divider();
		win_case(10'h080, 10'h040, 10'h064, 1'b1);
		win_case(10'h080, 10'h040, 10'h00A, 1'b0);
		win_case(10'h040, 10'h080, 10'h00A, 1'b1);
		win_case(10'h040, 10'h080, 10'h064, 1'b0);
		summarize();
	end
endmodule

`default_nettype wire
